// File: core/rtcs_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtcs_regs.svh"
// Summary of operation
// - An SCL low phase longer than 30 ms counts as a stuck bus.
// - After 35 ms of SCL low the serial interface sits in reset.
// - On timeout, stop driving SDA so the pullup lifts it.
// - Timeout detection works only while the crystal oscillator runs.
// - Set oscillator stop flag after the oscillator stops for 25 ms.
// - Pin A: open-drain active-low alarm output or reference clock input.
// - Pin B: push-pull square wave or active-low alarm output.
// - SDA is driven only low; highs come from the pullup.
// - Time base comes from the 32.768 kHz crystal.
// - Pin A feeds counters only when external clock enable is set.
module rtcs_supervisor
  import rtcs_pkg::*;
#(
  parameter int OSF_CYCLES = `RTCS_OSF_CYCLES,
  parameter int TIMEOUT_TICKS = `RTCS_TIMEOUT_TICKS
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_low_req_in,
  input wire logic xtal_in,
  input wire logic refclk_in_or_irq_a_pin_in,
  input wire logic external_clock_enable_in,
  input wire logic irq_a_n_in,
  input wire logic irq_b_n_in,
  input wire logic square_wave_in,
  input wire logic irq_b_select_in,
  input wire logic osf_clear_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic refclk_in_or_irq_a_pin_out,
  output logic refclk_in_or_irq_a_pin_oe_out,
  output logic square_wave_or_irq_b_pin_out,
  output logic square_wave_or_irq_b_pin_oe_out,
  output logic bus_reset_out,
  output logic oscillator_stop_flag_out,
  output logic time_tick_out
);
  // Counters are sized by the package types; refuse what does not fit
  if (TIMEOUT_TICKS < 1 || TIMEOUT_TICKS > 65535) begin : g_bad_timeout
    $error("TIMEOUT_TICKS out of range");
  end
  if (OSF_CYCLES < 2 || OSF_CYCLES > 16777215) begin : g_bad_osf
    $error("OSF_CYCLES out of range");
  end

  // Pins cross into the core clock through two flops
  rtcs_sync_if sync ();

  rtcs_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .scl_in(scl_in),
    .xtal_in(xtal_in),
    .refclk_in(refclk_in_or_irq_a_pin_in),
    .sync(sync.src)
  );

  // One-hot bus supervision states
  typedef enum logic [2:0] {
    RTCS_BUS_IDLE = 3'h1,
    RTCS_BUS_LOW = 3'h2,
    RTCS_BUS_RESET = 3'h4
  } rtcs_bus_e;

  // Rising-edge detect shared by crystal and reference clock
  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction : rise

  // Supervision state and edge-detect history
  rtcs_bus_e state_q, state_d;
  rtcs_tick_t low_cnt_q, low_cnt_d;
  rtcs_cyc_t stop_cnt_q, stop_cnt_d;
  logic xtal_prev_q, xtal_prev_d;
  logic ref_prev_q, ref_prev_d;
  logic osc_run_q, osc_run_d;
  logic osf_q, osf_d;
  logic xtal_tick;
  logic ref_tick;

  // Edge strobes; history resets high so reset gives no false rise
  assign xtal_tick = rise(sync.xtal, xtal_prev_q);
  assign ref_tick = rise(sync.refclk, ref_prev_q);

  // Oscillator stop detection: watchdog on crystal edges
  always_comb begin
    xtal_prev_d = sync.xtal;
    ref_prev_d = sync.refclk;
    stop_cnt_d = stop_cnt_q;
    osc_run_d = osc_run_q;
    osf_d = osf_q;
    if (xtal_tick) begin
      stop_cnt_d = '0;
      osc_run_d = 1'b1;
    end else if (stop_cnt_q < rtcs_cyc_t'(OSF_CYCLES - 1)) begin
      stop_cnt_d = stop_cnt_q + 24'h000001;
    end else begin
      osc_run_d = 1'b0;
    end
    // Set beats a simultaneous clear so a stop is never missed
    if (osf_clear_in) osf_d = 1'b0;
    if (!osc_run_d && osc_run_q) osf_d = 1'b1;
  end

  // Register stage for the oscillator watchdog
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      xtal_prev_q <= 1'b1;
      ref_prev_q <= 1'b1;
      stop_cnt_q <= '0;
      osc_run_q <= 1'b0;
      osf_q <= 1'b1; // Flag set at power-up: time not yet trusted
    end else begin
      xtal_prev_q <= xtal_prev_d;
      ref_prev_q <= ref_prev_d;
      stop_cnt_q <= stop_cnt_d;
      osc_run_q <= osc_run_d;
      osf_q <= osf_d;
    end
  end

  // Bus timeout machine counting crystal ticks while SCL is low
  always_comb begin
    state_d = state_q;
    low_cnt_d = low_cnt_q;
    case (state_q)
      RTCS_BUS_IDLE: begin
        // Counter held clear so each low phase is timed alone
        low_cnt_d = '0;
        if (!sync.scl) state_d = RTCS_BUS_LOW;
      end
      RTCS_BUS_LOW: begin
        // SCL high ends the low phase
        if (sync.scl) begin
          low_cnt_d = '0;
          state_d = RTCS_BUS_IDLE;
        end else if (osc_run_q && xtal_tick) begin
          // Threshold at 30 ms: above the 25 ms floor, below the 35 ms ceiling
          if (low_cnt_q >= rtcs_tick_t'(TIMEOUT_TICKS - 1)) begin
            state_d = RTCS_BUS_RESET;
          end else begin
            low_cnt_d = low_cnt_q + 16'h0001;
          end
        end
      end
      RTCS_BUS_RESET: begin
        // Stays in reset until SCL returns high, then back to idle to time the next SCL low
        if (sync.scl) state_d = RTCS_BUS_IDLE;
      end
      default: state_d = RTCS_BUS_IDLE;
    endcase
  end

  // Register stage for the bus machine
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= RTCS_BUS_IDLE;
      low_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      low_cnt_q <= low_cnt_d;
    end
  end

  // Pin drivers, all registered
  logic sda_oe_d;
  logic a_oe_d;
  logic b_d;
  logic reset_d;
  logic tick_d;
  always_comb begin
    sda_oe_d = sda_low_req_in && (state_d != RTCS_BUS_RESET);
    a_oe_d = !external_clock_enable_in && !irq_a_n_in;
    b_d = irq_b_select_in ? irq_b_n_in : square_wave_in;
    reset_d = (state_d == RTCS_BUS_RESET);
    // Reference edges only when enabled, otherwise crystal drives counters
    // Limitation: no fallback to the crystal if the reference is lost
    tick_d = external_clock_enable_in ? ref_tick : xtal_tick;
  end

  // Registered pin levels; reset keeps every driver off
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_oe_out <= 1'b0;
      refclk_in_or_irq_a_pin_oe_out <= 1'b0;
      square_wave_or_irq_b_pin_out <= 1'b1;
      bus_reset_out <= 1'b0;
      time_tick_out <= 1'b0;
    end else begin
      sda_oe_out <= sda_oe_d;
      refclk_in_or_irq_a_pin_oe_out <= a_oe_d;
      square_wave_or_irq_b_pin_out <= b_d;
      bus_reset_out <= reset_d;
      time_tick_out <= tick_d;
    end
  end

  // Open-drain data always low; push-pull pin B enabled out of reset
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_out <= 1'b0;
      refclk_in_or_irq_a_pin_out <= 1'b0;
      square_wave_or_irq_b_pin_oe_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      refclk_in_or_irq_a_pin_out <= 1'b0;
      square_wave_or_irq_b_pin_oe_out <= 1'b1;
    end
  end

  // Stop flag is sticky until cleared
  assign oscillator_stop_flag_out = osf_q;
endmodule : rtcs_supervisor
`default_nettype wire

// File: core/rtcs_sync.sv
`timescale 1ns/1ns
`default_nettype none
module rtcs_sync (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic xtal_in,
  input wire logic refclk_in,
  rtcs_sync_if.src sync
);
  logic [2:0] meta_q;
  logic [2:0] meta_d;
  logic [2:0] stab_q;
  logic [2:0] stab_d;

  // Two-stage synchroniser; first stage feeds only the second
  always_comb begin
    meta_d = {refclk_in, xtal_in, scl_in};
    stab_d = meta_q;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= 3'h7;
      stab_q <= 3'h7;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign sync.scl = stab_q[0];
  assign sync.xtal = stab_q[1];
  assign sync.refclk = stab_q[2];
endmodule : rtcs_sync
`default_nettype wire

// File: shared/rtcs_pkg.sv
package rtcs_pkg;
  typedef logic [15:0] rtcs_tick_t;
  typedef logic [23:0] rtcs_cyc_t;
endpackage : rtcs_pkg

// File: shared/rtcs_regs.svh
`ifndef RTCS_REGS_SVH
`define RTCS_REGS_SVH
// Core clock period in ns (10 MHz)
`define RTCS_CLK_PERIOD_NS 100
// Bus timeout window in ms
`define RTCS_TIMEOUT_MIN_MS 25
`define RTCS_TIMEOUT_MAX_MS 35
// Oscillator stop detect delay in ms
`define RTCS_OSF_TYP_MS 25
`define RTCS_OSF_MAX_MS 100
// Crystal rate in Hz
`define RTCS_XTAL_HZ 32768
// Timeout threshold: 30 ms in crystal ticks, between min and max
`define RTCS_TIMEOUT_MID_MS 30
`define RTCS_TIMEOUT_TICKS ((`RTCS_TIMEOUT_MID_MS * `RTCS_XTAL_HZ) / 1000)
// Oscillator stop: core cycles without a crystal edge, 25 ms
`define RTCS_OSF_CYCLES ((`RTCS_OSF_TYP_MS * 1000000) / `RTCS_CLK_PERIOD_NS)
`endif

// File: shared/rtcs_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
// Synchronised pin levels handed from the synchroniser to the core
interface rtcs_sync_if;
  logic scl;
  logic xtal;
  logic refclk;
  modport src (output scl, output xtal, output refclk);
  modport dst (input scl, input xtal, input refclk);
endinterface : rtcs_sync_if
`default_nettype wire

// File: sim/rtcs_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module rtcs_ctl (
  input wire logic clk_in,
  output logic scl_out
);
  // Idles high between frames
  initial scl_out = 1'h1;
  // Pull low and hold n cycles
  task automatic low(input int n);
    @(negedge clk_in);
    scl_out = 1'h0;
    repeat (n) @(negedge clk_in);
  endtask : low
  // Release high for n cycles
  task automatic high(input int n);
    scl_out = 1'h1;
    repeat (n) @(negedge clk_in);
  endtask : high
endmodule : rtcs_ctl
`default_nettype wire

// File: sim/rtcs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rtcs_sva #(
  parameter int OSF_CYCLES = 50
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_low_req_in,
  input wire logic xtal_in,
  input wire logic external_clock_enable_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic refclk_in_or_irq_a_pin_oe_out,
  input wire logic square_wave_or_irq_b_pin_oe_out,
  input wire logic bus_reset_out,
  input wire logic oscillator_stop_flag_out
);
  logic [23:0] xc_q, xc_d;
  logic xp_q;
  // Cycles since the last crystal rise
  always_comb xc_d = (xtal_in && !xp_q) ? 24'h0 : xc_q + 24'h1;
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
    if (!reset_n_in) {xc_q, xp_q} <= 25'h0;
    else {xc_q, xp_q} <= {xc_d, xtal_in};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  property p_low; sda_oe_out |-> !sda_out && $past(sda_low_req_in); endproperty
  property p_rel; bus_reset_out |-> !sda_oe_out; endproperty
  property p_rise; $rose(bus_reset_out) |-> !$past(scl_in, 3); endproperty
  property p_out; scl_in && bus_reset_out |-> ##[1:5] !bus_reset_out; endproperty
  property p_osc; $rose(bus_reset_out) |-> xc_q < OSF_CYCLES; endproperty
  property p_osf; $rose(oscillator_stop_flag_out) |-> xc_q >= OSF_CYCLES; endproperty
  property p_pina; $past(external_clock_enable_in) |-> !refclk_in_or_irq_a_pin_oe_out; endproperty
  property p_pinb; $past(reset_n_in) |-> square_wave_or_irq_b_pin_oe_out; endproperty
  a_low: assert property (p_low) else $error("sda driven high");
  a_rel: assert property (p_rel) else $error("sda held in reset");
  a_rise: assert property (p_rise) else $error("timeout with scl high");
  a_out: assert property (p_out) else $error("reset stuck");
  a_osc: assert property (p_osc) else $error("timeout, crystal stopped");
  a_osf: assert property (p_osf) else $error("stop flag early");
  a_pina: assert property (p_pina) else $error("pin A driven as input");
  a_pinb: assert property (p_pinb) else $error("pin B not driven");
  c_to: cover property ($rose(bus_reset_out));
  c_osf: cover property ($rose(oscillator_stop_flag_out));
  c_pa: cover property ($rose(refclk_in_or_irq_a_pin_oe_out));
endmodule : rtcs_sva
bind rtcs_supervisor rtcs_sva #(.OSF_CYCLES(OSF_CYCLES)) u_rtcs_sva (.*);
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'h0, rst_n = 1'h0, req = 1'h0, xt = 1'h0, xen = 1'h1, ece = 1'h0;
  logic ian = 1'h1, ibn = 1'h1, sq = 1'h0, bsel = 1'h0, oclr = 1'h0, rf = 1'h0;
  logic scl, sda, soe, aoe, pb, boe, brst, oscillator_stop_flag, pa, tk;
  int error_cnt = 0, tests_run = 0;
  // Core clock
  always #50 clk = ~clk;
  // Crystal, 800 ns, off phase; xen low stops it
  initial begin
    #17;
    forever #400 if (xen) xt = ~xt;
  end
  rtcs_ctl u_rtcs_ctl (.clk_in(clk), .scl_out(scl));
  // Short counts keep the run brief
  rtcs_supervisor #(.OSF_CYCLES(50), .TIMEOUT_TICKS(4)) u_rtcs_supervisor (
    .clk_sys_in(clk), .reset_n_in(rst_n), .scl_in(scl), .sda_low_req_in(req),
    .xtal_in(xt), .refclk_in_or_irq_a_pin_in(rf), .external_clock_enable_in(ece),
    .irq_a_n_in(ian), .irq_b_n_in(ibn), .square_wave_in(sq), .irq_b_select_in(bsel),
    .osf_clear_in(oclr), .sda_out(sda), .sda_oe_out(soe),
    .refclk_in_or_irq_a_pin_out(pa), .refclk_in_or_irq_a_pin_oe_out(aoe),
    .square_wave_or_irq_b_pin_out(pb), .square_wave_or_irq_b_pin_oe_out(boe),
    .bus_reset_out(brst), .oscillator_stop_flag_out(oscillator_stop_flag), .time_tick_out(tk));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input logic a, input logic e);
    tests_run++;
    if (a !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %b", $time, a);
    end
  endtask : chk
  task automatic complete_run;
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // Two lows each under the threshold; counter must clear between
  task automatic t_short;
    req = 1'h1;
    u_rtcs_ctl.low(20);
    u_rtcs_ctl.high(4);
    u_rtcs_ctl.low(20);
    chk(brst, 1'h0);
    chk(soe, 1'h1);
    chk(sda, 1'h0);
    u_rtcs_ctl.high(4);
  endtask : t_short
  // Stuck low: reset and release sda, recover on high
  task automatic t_stuck;
    u_rtcs_ctl.low(45);
    chk(brst, 1'h1);
    chk(soe, 1'h0);
    u_rtcs_ctl.high(6);
    chk(brst, 1'h0);
    chk(soe, 1'h1);
    req = 1'h0;
  endtask : t_stuck
  task automatic t_pins;
    ian = 1'h0;
    ibn = 1'h0;
    bsel = 1'h1;
    cyc(2);
    chk(aoe, 1'h1);
    chk({pb, boe} == 2'h1, 1'h1);
    ece = 1'h1;
    bsel = 1'h0;
    sq = 1'h1;
    cyc(2);
    chk(aoe, 1'h0);
    chk(pb, 1'h1);
    ece = 1'h0;
  endtask : t_pins
  // Time base: crystal edges, then only reference edges when enabled
  task automatic t_tick;
    int n;
    n = 0;
    repeat (32) begin
      cyc(1);
      if (tk === 1'h1) n++;
    end
    chk(n == 4, 1'h1);
    chk(pa, 1'h0);
    ece = 1'h1;
    cyc(4);
    n = 0;
    repeat (8) begin
      cyc(1);
      if (tk === 1'h1) n++;
    end
    rf = 1'h1;
    repeat (8) begin
      cyc(1);
      if (tk === 1'h1) n++;
    end
    chk(n == 1, 1'h1);
    rf = 1'h0;
    ece = 1'h0;
    cyc(4);
  endtask : t_tick
  // Mid-run reset: drivers off, flag set, then drivers resume
  task automatic t_reset;
    req = 1'h1;
    rst_n = 1'h0;
    cyc(2);
    chk(oscillator_stop_flag, 1'h1);
    chk(soe, 1'h0);
    chk(boe, 1'h0);
    rst_n = 1'h1;
    cyc(2);
    chk(boe, 1'h1);
    chk(soe, 1'h1);
    chk(brst, 1'h0);
    req = 1'h0;
  endtask : t_reset
  // Crystal stops: flag in window, no timeout meanwhile
  task automatic t_osf;
    oclr = 1'h1;
    cyc(1);
    oclr = 1'h0;
    cyc(2);
    chk(oscillator_stop_flag, 1'h0);
    xen = 1'h0;
    cyc(40);
    chk(oscillator_stop_flag, 1'h0);
    cyc(20);
    chk(oscillator_stop_flag, 1'h1);
    u_rtcs_ctl.low(60);
    chk(brst, 1'h0);
    u_rtcs_ctl.high(2);
    xen = 1'h1;
  endtask : t_osf
  initial begin
    cyc(10);
    rst_n = 1'h1;
    cyc(2);
    t_short;
    t_stuck;
    t_pins;
    t_tick;
    t_osf;
    t_reset;
    complete_run;
  end
  // About 300 cycles expected; far margin
  initial begin
    #1000000;
    error_cnt++;
    complete_run;
  end
endmodule : testbench
`default_nettype wire
